// File: core/emb_pkg.sv
// Constants, register map and state codes for the external memory bus block.
// Assumes a single 100 MHz clock and the plain register port of the top module.
package emb_pkg;

    // ------------------------------------------------------------
    // Register offsets on the plain register port
    // ------------------------------------------------------------
    localparam logic [3:0] REG_MODE = 4'h0;
    localparam logic [3:0] REG_CTRL = 4'h1;
    localparam logic [3:0] REG_P0DATA = 4'h2;
    localparam logic [3:0] REG_STATUS = 4'h3;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    // Mode register: nibble address enables, nibble directions, timing, float
    localparam int MODE_LO_ADDR = 0;
    localparam int MODE_LO_IN = 2;
    localparam int MODE_EXT_TIMING = 4;
    localparam int MODE_FLOAT = 5;
    // Control register
    localparam int CTRL_SPACE_EN = 0;
    localparam int CTRL_HS_EN = 1;
    // Status register
    localparam int STAT_BUSY = 0;
    localparam int STAT_RESET = 1;
    localparam int STAT_FLOAT = 2;
    localparam int STAT_BOOT = 3;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    // Both upper-port nibbles as address, I/O directions input, extended timing on
    localparam logic [7:0] MODE_RESET = 8'h1f;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] P0DATA_RESET = 8'h00;
    localparam logic [15:0] BOOT_ADDR = 16'h000c;

    // ------------------------------------------------------------
    // Cycle counts
    // ------------------------------------------------------------
    localparam logic [2:0] RST_FILTER_CLKS = 3'h4;
    localparam logic [4:0] RST_HOLD_CLKS = 5'h12;
    localparam logic [1:0] EXT_WAIT_CLKS = 2'h2;

    // ------------------------------------------------------------
    // Bus cycle states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_LATCH = 3'b010,
        ST_DSTRB = 3'b011,
        ST_END = 3'b100
    } emb_state_e;

endpackage

// File: core/emb_rst_filter.sv
// Reset pin filter and internal reset stretcher.
// Assumes the reset pin is already synchronous to mclk.
module emb_rst_filter (
    // Clock and power reset
    input wire logic mclk,
    input wire logic rst_n,
    // Reset pin
    input wire logic extResetN,
    // Filtered internal reset
    output logic intReset,
    output logic detected
);

    logic [2:0] lowCnt;
    logic [4:0] holdCnt;

    // Count consecutive low samples; a glitch restarts the count
    always_ff @(posedge mclk) begin
        if (!rst_n || extResetN) begin
            lowCnt <= 3'h0;
        end else if (lowCnt != emb_pkg::RST_FILTER_CLKS) begin
            lowCnt <= lowCnt + 3'h1;
        end
    end

    assign detected = (lowCnt == emb_pkg::RST_FILTER_CLKS);

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            intReset <= 1'b1;
        end else if (detected) begin
            intReset <= 1'b1;
        end else if (holdCnt == emb_pkg::RST_HOLD_CLKS && extResetN) begin
            intReset <= 1'b0;
        end
    end

    // Hold counter saturates so a long pin reset simply waits for the pin
    always_ff @(posedge mclk) begin
        if (!rst_n || !intReset) begin
            holdCnt <= 5'h0;
        end else if (holdCnt != emb_pkg::RST_HOLD_CLKS) begin
            holdCnt <= holdCnt + 5'h1;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_SHORT_PULSE: assert property (@(posedge mclk) disable iff (!rst_n)
        (!intReset && !detected) |=> !intReset)
        else $error("Reset latched without a full filter window");
    AST_HOLD_MIN: assert property (@(posedge mclk) disable iff (!rst_n)
        (intReset && holdCnt < emb_pkg::RST_HOLD_CLKS) |=> intReset)
        else $error("Internal reset released before its hold count");
    AST_HOLD_PIN: assert property (@(posedge mclk) disable iff (!rst_n)
        (intReset && !extResetN) |=> intReset)
        else $error("Internal reset released while the pin is low");

endmodule // emb_rst_filter

// File: core/emb_bus.sv
// External memory bus interface: multiplexed address/data on two ports,
// strobes, read/write and data space select, plus the reset sequence.
// Assumes a core issues transfers on the request port and software
// reaches the mode registers over the plain register port.
//
// The register addresses and the plain strobed port are this design's own decisions.
module emb_bus (
    // Clock and power reset
    input wire logic mclk,
    input wire logic rst_n,
    // Reset pin
    input wire logic extResetN,
    // Register port
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdata,
    // Transfer request port
    input wire logic memReq,
    input wire logic memWrite,
    input wire logic memDataSpace,
    input wire logic [15:0] memAddr,
    input wire logic [7:0] memWdata,
    output logic memReady,
    output logic memDone,
    output logic [7:0] memRdata,
    output logic memBoot,
    // Lower port, multiplexed address and data
    input wire logic [7:0] lowPortIn,
    output logic [7:0] lowPortOut,
    output logic lowPortOe,
    // Upper port, high address or nibble I/O
    input wire logic [7:0] upPortIn,
    output logic [7:0] upPortOut,
    output logic [7:0] upPortOe,
    // Strobes and read/write
    output logic address_strobe_n,
    output logic addressStrobeOe,
    output logic data_strobe_n,
    output logic dataStrobeOe,
    output logic readWriteN,
    output logic readWriteOe,
    // Data space select
    output logic data_space_select_n,
    output logic dataSpaceOe,
    // Upper port handshake line enables
    output logic upper_port_data_valid_n,
    output logic davOe,
    output logic upper_port_ready,
    output logic rdyOe
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    emb_pkg::emb_state_e state;
    logic rstSeq;
    logic rstDetected;
    logic rstSeqD;
    logic bootPending;
    logic [7:0] modeReg;
    logic [7:0] ctrlReg;
    logic [7:0] p0Data;
    logic floated;
    logic [15:0] addrHold;
    logic [7:0] wdataHold;
    logic isWrite;
    logic isData;
    logic [1:0] waitCnt;
    logic asToggle;
    logic takeReq;
    logic startBoot;
    logic inWriteCycle;
    logic strobeActive;

    // ------------------------------------------------------------
    // Reset filter
    // ------------------------------------------------------------
    emb_rst_filter u_filter (
        .mclk(mclk),
        .rst_n(rst_n),
        .extResetN(extResetN),
        .intReset(rstSeq),
        .detected(rstDetected)
    );

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    // mode register write
    always_ff @(posedge mclk) begin
        if (!rst_n || rstSeq) begin
            modeReg <= emb_pkg::MODE_RESET;
        end else if (regWr && regAddr == emb_pkg::REG_MODE) begin
            modeReg <= regWdata;
        end
    end

    // Control register: data space select and handshake enables
    always_ff @(posedge mclk) begin
        if (!rst_n || rstSeq) begin
            ctrlReg <= emb_pkg::CTRL_RESET;
        end else if (regWr && regAddr == emb_pkg::REG_CTRL) begin
            ctrlReg <= regWdata;
        end
    end

    // Output latch for upper-port nibbles used as I/O
    always_ff @(posedge mclk) begin
        if (!rst_n || rstSeq) begin
            p0Data <= emb_pkg::P0DATA_RESET;
        end else if (regWr && regAddr == emb_pkg::REG_P0DATA) begin
            p0Data <= regWdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n || rstSeq) begin
            floated <= 1'b0;
        end else if (regWr && regAddr == emb_pkg::REG_MODE && regWdata[emb_pkg::MODE_FLOAT]) begin
            floated <= 1'b1;
        end
    end

    // Read data stands one cycle only; unmapped offsets read zero
    always_ff @(posedge mclk) begin
        if (!rst_n || !regRd) begin
            regRdata <= 8'h00;
        end else begin
            case (regAddr)
                emb_pkg::REG_MODE: begin
                    regRdata <= {modeReg[7:6], floated, modeReg[4:0]};
                end
                emb_pkg::REG_CTRL: begin
                    regRdata <= ctrlReg;
                end
                emb_pkg::REG_P0DATA: begin
                    regRdata <= upPortIn;
                end
                emb_pkg::REG_STATUS: begin
                    regRdata <= {4'h0, bootPending, floated, rstSeq, state != emb_pkg::ST_IDLE};
                end
                default: begin
                    regRdata <= 8'h00;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Boot fetch
    // ------------------------------------------------------------
    // fetch 000C after release
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rstSeqD <= 1'b1;
            bootPending <= 1'b0;
        end else begin
            rstSeqD <= rstSeq;
            if (rstSeq) begin
                bootPending <= 1'b0;
            end else if (rstSeqD) begin
                bootPending <= 1'b1;
            end else if (startBoot) begin
                bootPending <= 1'b0;
            end
        end
    end

    // A floated bus cannot run cycles, so requests wait until reset
    assign memReady = (state == emb_pkg::ST_IDLE) && !rstSeq && !bootPending && !floated;
    assign takeReq = memReady && memReq;
    assign startBoot = (state == emb_pkg::ST_IDLE) && !rstSeq && bootPending && !rstSeqD
        && !floated;

    // ------------------------------------------------------------
    // Bus cycle sequencer
    // ------------------------------------------------------------
    // one data strobe per cycle
    always_ff @(posedge mclk) begin
        if (!rst_n || rstSeq) begin
            state <= emb_pkg::ST_IDLE;
            waitCnt <= 2'h0;
        end else begin
            case (state)
                emb_pkg::ST_IDLE: begin
                    if (takeReq || startBoot) begin
                        state <= emb_pkg::ST_ADDR;
                    end
                end
                emb_pkg::ST_ADDR: begin
                    state <= emb_pkg::ST_LATCH;
                end
                emb_pkg::ST_LATCH: begin
                    state <= emb_pkg::ST_DSTRB;
                    // Slow memories get extra strobe cycles
                    waitCnt <= modeReg[emb_pkg::MODE_EXT_TIMING] ? emb_pkg::EXT_WAIT_CLKS : 2'h0;
                end
                emb_pkg::ST_DSTRB: begin
                    if (waitCnt == 2'h0) begin
                        state <= emb_pkg::ST_END;
                    end else begin
                        waitCnt <= waitCnt - 2'h1;
                    end
                end
                emb_pkg::ST_END: begin
                    state <= emb_pkg::ST_IDLE;
                end
                default: begin
                    state <= emb_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Capture the transfer; the boot fetch is a program read
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            addrHold <= 16'h0000;
            wdataHold <= 8'h00;
            isWrite <= 1'b0;
            isData <= 1'b0;
            memBoot <= 1'b0;
        end else if (startBoot) begin
            addrHold <= emb_pkg::BOOT_ADDR;
            isWrite <= 1'b0;
            isData <= 1'b0;
            memBoot <= 1'b1;
        end else if (takeReq) begin
            addrHold <= memAddr;
            wdataHold <= memWdata;
            isWrite <= memWrite;
            isData <= memDataSpace;
            memBoot <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            memRdata <= 8'h00;
        end else if (state == emb_pkg::ST_DSTRB && waitCnt == 2'h0 && !isWrite) begin
            memRdata <= lowPortIn;
        end
    end

    assign memDone = (state == emb_pkg::ST_END);

    // ------------------------------------------------------------
    // Strobes during the reset cycle
    // ------------------------------------------------------------
    // toggle every clock
    always_ff @(posedge mclk) begin
        if (!rst_n || !rstSeq) begin
            asToggle <= 1'b1;
        end else begin
            asToggle <= !asToggle;
        end
    end

    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    assign strobeActive = (state == emb_pkg::ST_DSTRB);
    assign inWriteCycle = isWrite && (state != emb_pkg::ST_IDLE);

    assign address_strobe_n = rstSeq ? asToggle : (state != emb_pkg::ST_ADDR);
    assign data_strobe_n = rstSeq ? 1'b0 : !strobeActive;
    assign readWriteN = !inWriteCycle;
    assign addressStrobeOe = !floated;
    assign dataStrobeOe = !floated;
    assign readWriteOe = !floated;

    assign lowPortOut = (state == emb_pkg::ST_ADDR || state == emb_pkg::ST_LATCH)
        ? addrHold[7:0] : wdataHold;
    assign lowPortOe = !floated && !rstSeq && (state == emb_pkg::ST_ADDR
        || state == emb_pkg::ST_LATCH || (isWrite && (strobeActive || state == emb_pkg::ST_END)));

    for (genvar g = 0; g < 2; g++) begin : g_nib
        logic addrMode;
        logic inDir;
        assign addrMode = modeReg[emb_pkg::MODE_LO_ADDR + g];
        assign inDir = modeReg[emb_pkg::MODE_LO_IN + g];
        assign upPortOut[4*g +: 4] = addrMode ? addrHold[8 + 4*g +: 4] : p0Data[4*g +: 4];
        assign upPortOe[4*g +: 4] = (floated || (!addrMode && inDir)) ? 4'h0 : 4'hf;
    end

    assign data_space_select_n = !(isData && state != emb_pkg::ST_IDLE);
    assign dataSpaceOe = ctrlReg[emb_pkg::CTRL_SPACE_EN];

    // handshake direction follows the upper nibble direction bit
    assign upper_port_data_valid_n = 1'b1;
    assign upper_port_ready = 1'b0;
    assign davOe = ctrlReg[emb_pkg::CTRL_HS_EN] && !modeReg[emb_pkg::MODE_LO_IN + 1];
    assign rdyOe = ctrlReg[emb_pkg::CTRL_HS_EN] && modeReg[emb_pkg::MODE_LO_IN + 1];

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    sequence sAddrPhase;
        !address_strobe_n && data_strobe_n;
    endsequence
    sequence sLatchPhase;
        address_strobe_n && data_strobe_n;
    endsequence

    AST_ADDR_THEN_DATA: assert property (!rstSeq && state == emb_pkg::ST_IDLE && takeReq
        |=> sAddrPhase ##1 sLatchPhase ##1 !data_strobe_n)
        else $error("Address strobe did not open the bus cycle");
    // Strobe release at the end of the reset cycle is not a transfer
    AST_STROBE_ONCE: assert property (!rstSeq && !$past(rstSeq) && $rose(data_strobe_n)
        |-> memDone ##1 (data_strobe_n && state == emb_pkg::ST_IDLE))
        else $error("Data strobe end not matched to one transfer");
    AST_WR_DATA: assert property (!rstSeq && !floated && !data_strobe_n && isWrite
        |-> lowPortOe && lowPortOut == wdataHold)
        else $error("Write data not driven during data strobe");
    AST_ADDR_HOLD: assert property (!rstSeq && !$past(rstSeq) && !floated
        && $rose(address_strobe_n) |-> lowPortOe && lowPortOut == addrHold[7:0])
        else $error("Address not valid at address strobe end");
    AST_FLOAT_ALL: assert property (floated
        |-> !addressStrobeOe && !dataStrobeOe && !readWriteOe && !lowPortOe && upPortOe == 8'h00)
        else $error("Bus pin driven while floated");
    AST_FLOAT_STICKY: assert property (floated && !rstSeq |=> floated)
        else $error("Float state left without hardware reset");
    AST_RW_WRITE: assert property (!data_strobe_n && !rstSeq && isWrite |-> !readWriteN)
        else $error("Read/write not low during write");
    AST_RW_READ: assert property (state != emb_pkg::ST_IDLE && !isWrite |-> readWriteN)
        else $error("Read/write low during read");
    AST_RST_STROBES: assert property (rstSeq && $past(rstSeq)
        |=> (!rstSeq || (!data_strobe_n && address_strobe_n != $past(address_strobe_n))))
        else $error("Reset cycle strobe pattern wrong");
    AST_BOOT: assert property ($fell(rstSeq) && !floated
        |-> ##[1:3] (state == emb_pkg::ST_ADDR && addrHold == emb_pkg::BOOT_ADDR && memBoot))
        else $error("First fetch not from boot address");
    AST_SPACE_SEL: assert property (state != emb_pkg::ST_IDLE |-> data_space_select_n == !isData)
        else $error("Data space select wrong");
    AST_MODE_RESET: assert property ($fell(rstSeq) |-> modeReg == emb_pkg::MODE_RESET)
        else $error("Mode not at reset value after reset");

endmodule // emb_bus

// File: sim/emb_mem_model.sv
// External memory model for the bus block: one 64 KB byte array.
// Assumes the block's pins are wired straight to it; slowMem delays read data.
module emb_mem_model (
    // Clock and speed
    input wire logic mclk,
    input wire logic slowMem,
    // Bus pins from the block
    input wire logic address_strobe_n,
    input wire logic data_strobe_n,
    input wire logic readWriteN,
    input wire logic [7:0] lowPortOut,
    input wire logic lowPortOe,
    input wire logic [7:0] upPortOut,
    // Read data back to the block
    output logic [7:0] lowPortIn
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] mem [0:65535];
    logic [15:0] addr = 16'h0000;
    logic [7:0] lastVal = 8'h00;
    logic [1:0] lowCnt = 2'h0;
    always @(posedge address_strobe_n) addr <= {upPortOut, lowPortOut};
    // write data taken while still driven
    always @(posedge data_strobe_n) if (!readWriteN && lowPortOe) mem[addr] <= lowPortOut;
    // Count strobe-low cycles; the released bus toggles so stale data never matches
    always @(posedge mclk) begin
        lowCnt <= data_strobe_n ? 2'h0 : (lowCnt == 2'h3 ? lowCnt : lowCnt + 2'h1);
        lastVal <= lowPortIn;
    end
    // slow memory is valid only from the third strobe-low cycle
    wire logic driving = !data_strobe_n && readWriteN && !lowPortOe && !(slowMem && lowCnt < 2'h2);
    assign lowPortIn = driving ? mem[addr] : ~lastVal;
endmodule // emb_mem_model

// File: sim/testbench.sv
// Self-checking bench for the external memory bus block.
// Assumes emb_bus and the memory model; one 100 MHz clock.
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic extResetN = 1'b1;
    logic [3:0] regAddr = 4'h0;
    logic [7:0] regWdata = 8'h00;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic memReq = 1'b0;
    logic memWrite = 1'b0;
    logic memDataSpace = 1'b0;
    logic [15:0] memAddr = 16'h0000;
    logic [7:0] memWdata = 8'h00;
    logic [7:0] upPortIn = 8'h3c;
    logic slowMem = 1'b1;
    logic [7:0] regRdata, memRdata, lowPortIn, lowPortOut, upPortOut, upPortOe, v;
    logic memReady, memDone, memBoot, lowPortOe, address_strobe_n, addressStrobeOe, davOe, rdyOe;
    logic data_strobe_n, dataStrobeOe, readWriteN, readWriteOe, data_space_select_n, dataSpaceOe;
    int mismatches = 0;
    int cmp_count = 0;
    int cycles = 0;
    int dataFalls = 0;
    int asFalls = 0;

    emb_bus u_emb_bus (
        .mclk(mclk), .rst_n(rst_n), .extResetN(extResetN), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .memReq(memReq), .memWrite(memWrite), .memDataSpace(memDataSpace),
        .memAddr(memAddr), .memWdata(memWdata), .memReady(memReady), .memDone(memDone),
        .memRdata(memRdata), .memBoot(memBoot), .lowPortIn(lowPortIn),
        .lowPortOut(lowPortOut), .lowPortOe(lowPortOe), .upPortIn(upPortIn),
        .upPortOut(upPortOut), .upPortOe(upPortOe), .address_strobe_n(address_strobe_n),
        .addressStrobeOe(addressStrobeOe), .data_strobe_n(data_strobe_n),
        .dataStrobeOe(dataStrobeOe), .readWriteN(readWriteN), .readWriteOe(readWriteOe),
        .data_space_select_n(data_space_select_n), .dataSpaceOe(dataSpaceOe),
        .upper_port_data_valid_n(), .davOe(davOe), .upper_port_ready(), .rdyOe(rdyOe)
    );
    emb_mem_model u_emb_mem_model (
        .mclk(mclk), .slowMem(slowMem), .address_strobe_n(address_strobe_n),
        .data_strobe_n(data_strobe_n), .readWriteN(readWriteN), .lowPortOut(lowPortOut),
        .lowPortOe(lowPortOe), .upPortOut(upPortOut), .lowPortIn(lowPortIn)
    );

    // Clock, strobe edge counters and hang guard
    initial forever #5 mclk = ~mclk;
    always @(negedge data_strobe_n) dataFalls++;
    always @(negedge address_strobe_n) asFalls++;
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            finish_test();
        end
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string msg);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic finish_test;
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask

    task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge mclk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge mclk);
        regRd <= 1'b0;
        #1;
        d = regRdata;
    endtask

    // Boot fetch after any reset: slow memory under extended timing
    task automatic wait_boot;
        int n;
        for (n = 0; n < 200 && !(memDone === 1'b1 && memBoot === 1'b1); n++) @(posedge mclk) #1;
        check(n < 200, 1'b1, "boot done");
        check(u_emb_mem_model.addr, emb_pkg::BOOT_ADDR, "boot addr");
        check(memRdata, 8'hc9, "boot data");
    endtask

    // One transfer, checked cycle by cycle against the walk
    task automatic xfer(input logic wr, input logic ds, input logic [15:0] a,
                        input logic [7:0] d, input int lat);
        int n;
        for (n = 0; n < 50 && memReady !== 1'b1; n++) @(posedge mclk) #1;
        @(posedge mclk);
        memReq <= 1'b1;
        memWrite <= wr;
        memDataSpace <= ds;
        memAddr <= a;
        memWdata <= d;
        dataFalls = 0;
        asFalls = 0;
        for (n = 0; n < 10 && memDone !== 1'b1; ) begin
            @(posedge mclk);
            memReq <= 1'b0;
            #1;
            n++;
            if (n == 1) begin
                check({address_strobe_n, lowPortOe}, 2'b01, "addr phase");
                check({upPortOut, lowPortOut}, a, "addr out");
                check(data_space_select_n, !ds, "space select");
            end
            if (n == 2) check({address_strobe_n, lowPortOut}, {1'b1, a[7:0]}, "addr held");
            if (n == 3) begin
                check({data_strobe_n, readWriteN, lowPortOe}, {1'b0, !wr, wr}, "data phase");
                if (wr) check(lowPortOut, d, "write data");
            end
        end
        check(n, lat, "latency");
        check(memBoot, 1'b0, "not boot");
        check({dataFalls[3:0], asFalls[3:0]}, 8'h11, "one strobe each");
        if (!wr) check(memRdata, d, "read data");
    endtask

    task automatic test_xfers;
        reg_wr(emb_pkg::REG_CTRL, 8'h01);
        xfer(1'b1, 1'b1, 16'h1234, 8'ha5, 6);
        check(dataSpaceOe, 1'b1, "space oe");
        xfer(1'b0, 1'b1, 16'h1234, 8'ha5, 6);
        xfer(1'b1, 1'b0, 16'h00ff, 8'h3c, 6);
        xfer(1'b0, 1'b0, 16'h00ff, 8'h3c, 6);
        reg_wr(emb_pkg::REG_MODE, 8'h0f);
        slowMem <= 1'b0;
        xfer(1'b0, 1'b1, 16'h1234, 8'ha5, 4);
        $display("test xfers done");
    endtask

    task automatic test_nibble;
        reg_wr(emb_pkg::REG_MODE, 8'h0a);
        reg_wr(emb_pkg::REG_P0DATA, 8'h5a);
        @(posedge mclk) #1;
        check({upPortOe[3:0], upPortOut[3:0]}, 8'hfa, "low nibble out");
        reg_wr(emb_pkg::REG_MODE, 8'h01);
        // Handshake enabled; its direction follows the high nibble direction bit only
        reg_wr(emb_pkg::REG_CTRL, 8'h02);
        @(posedge mclk) #1;
        check({upPortOe[7:4], upPortOut[7:4]}, 8'hf5, "high nibble out");
        check({davOe, rdyOe, dataSpaceOe}, 3'b100, "hs out");
        reg_wr(emb_pkg::REG_MODE, 8'h0e);
        @(posedge mclk) #1;
        check(upPortOe[3:0], 4'h0, "low nibble in");
        check({davOe, rdyOe, dataSpaceOe}, 3'b010, "hs in");
        reg_rd(emb_pkg::REG_P0DATA, v);
        check(v, 8'h3c, "pin read");
        reg_rd(4'h7, v);
        check(v, 8'h00, "unmapped");
        reg_wr(emb_pkg::REG_MODE, 8'h0f);
        $display("test nibble done");
    endtask

    // Reset pin pulse of len clocks; counts data strobe low cycles
    task automatic test_filter(input int len, input int minLow);
        int n;
        int low;
        low = 0;
        slowMem <= 1'b1;
        @(posedge mclk);
        extResetN <= 1'b0;
        for (n = 0; n < 300 && !(low == 0 && n > len + 20); n++) begin
            @(posedge mclk);
            if (n == len - 1) extResetN <= 1'b1;
            #1;
            if (data_strobe_n === 1'b0) low++;
            else if (low > 0) break;
        end
        if (minLow == 0) check(low, 0, "short pulse");
        else check(low >= minLow, 1'b1, "reset stretch");
        if (minLow > 0) wait_boot();
        reg_rd(emb_pkg::REG_MODE, v);
        if (minLow > 0) check(v, emb_pkg::MODE_RESET, "mode reset");
        $display("test filter %0d done", len);
    endtask

    task automatic test_float;
        reg_wr(emb_pkg::REG_MODE, 8'h3f);
        @(posedge mclk) #1;
        check({lowPortOe, addressStrobeOe, dataStrobeOe, readWriteOe, upPortOe, memReady},
              13'h0000, "floated");
        reg_wr(emb_pkg::REG_MODE, 8'h1f);
        reg_rd(emb_pkg::REG_STATUS, v);
        check({v[emb_pkg::STAT_FLOAT], addressStrobeOe}, 2'b10, "still floated");
        @(posedge mclk);
        rst_n <= 1'b0;
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        wait_boot();
        check(addressStrobeOe, 1'b1, "float left");
        $display("test float done");
    endtask

    // Power reset; the address strobe toggles in the stretch that follows it
    task automatic test_reset;
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk) #1;
        v[0] = address_strobe_n;
        @(posedge mclk) #1;
        check({address_strobe_n, data_strobe_n}, {~v[0], 1'b0}, "reset strobes");
        wait_boot();
        reg_rd(emb_pkg::REG_MODE, v);
        check(v, emb_pkg::MODE_RESET, "mode reset");
        $display("test reset done");
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        u_emb_mem_model.mem[16'h000c] = 8'hc9;
        test_reset();
        test_xfers();
        test_nibble();
        test_filter(3, 0);
        test_filter(5, 18);
        test_filter(30, 26);
        test_float();
        finish_test();
    end
endmodule // testbench
